// File: rtl/bec_error_counter.sv
// Contract
// - Live lock status bit reads 0 while checker is locked, 1 otherwise.
// - Latched update-done flag sets when live update-done rises.
// - Latched bit-error flag sets on every detected bit error.
// - Latched count-nonzero flag sets when live count-nonzero rises.
// - Latched lock-change flag sets on either edge of lock status.
// - Update-done interrupt requested when its enable and latched flag set.
// - Bit-error interrupt needs enable, latched flag and port enable.
// - Count-nonzero interrupt needs enable, latched flag and port enable.
// - Lock-change interrupt needs enable, latched flag and port enable.
// - Tally is 24 bits; low 16 bits in first count register, reset zero.
// - Upper 8 bits in second count register bits 7..0; 15..8 read zero.
// - Each bit error in lock counts; tally saturates at maximum, never wraps.
// - Tally does not advance while checker is out of lock.
// - Visible count registers load only on update strobe, else hold.
// - Live update-done rises after update, drops when request goes low.
// - Live count-nonzero is tally nonzero; cleared by a counter update.
`timescale 1ns/1ps
`default_nettype none

module brx_error_counter
	import brx_pkg::*;
#(
	parameter int TALLY_W = BRX_TALLY_W
) (
	input  wire logic                  core_clk_in,
	input  wire logic                  reset_n_in,
	input  wire logic                  pattern_unlocked_in,
	input  wire logic                  bit_error_in,
	input  wire logic                  perf_update_strobe_in,
	input  wire logic                  port_irq_enable_field_in,
	input  wire logic [BRX_ADDR_W-1:0] addr_in,
	input  wire logic [BRX_DATA_W-1:0] wr_data_in,
	input  wire logic                  wr_strobe_in,
	input  wire logic                  rd_strobe_in,
	output logic      [BRX_DATA_W-1:0] rd_data_out,
	output logic                       irq_out
);

	// ****************************************
	// State
	// ****************************************
	logic                  unlocked_q;
	logic                  strobe_q;
	logic                  update_done_q;
	logic                  update_done_d;
	logic                  nonzero_q;
	logic [TALLY_W-1:0]    tally_q;
	logic [TALLY_W-1:0]    tally_d;
	logic [TALLY_W-1:0]    visible_q;
	brx_flags_t            latched_q;
	brx_flags_t            latched_d;
	brx_flags_t            irq_en_q;
	brx_flags_t            events;
	brx_flags_t            gated;
	logic [BRX_DATA_W-1:0] rd_data_q;
	logic [BRX_DATA_W-1:0] rd_mux;
	logic                  irq_q;

	// ****************************************
	// Address decode
	// ****************************************
	wire logic sel_live     = (addr_in == BRX_OFS_LIVE);
	wire logic sel_latched  = (addr_in == BRX_OFS_LATCHED);
	wire logic sel_irq_en   = (addr_in == BRX_OFS_IRQ_EN);
	wire logic sel_count_lo = (addr_in == BRX_OFS_COUNT_LO);
	wire logic sel_count_hi = (addr_in == BRX_OFS_COUNT_HI);
	wire logic wr_latched   = wr_strobe_in & sel_latched;
	wire logic wr_irq_en    = wr_strobe_in & sel_irq_en;

	// ****************************************
	// Live status and event detection
	// ****************************************
	// Update strobe acts on its rising edge only
	wire logic update_pulse = perf_update_strobe_in & ~strobe_q;
	// Counting pauses out of lock
	wire logic count_now    = bit_error_in & ~pattern_unlocked_in;
	wire logic tally_full   = (tally_q == BRX_TALLY_MAX[TALLY_W-1:0]);
	wire logic nonzero_live = (tally_q != BRX_TALLY_RST[TALLY_W-1:0]);

	assign update_done_d = perf_update_strobe_in & (update_done_q | update_pulse);

	assign events.update_done   = update_done_d & ~update_done_q;
	assign events.bit_error     = bit_error_in;
	assign events.count_nonzero = nonzero_live & ~nonzero_q;
	assign events.lock_change   = pattern_unlocked_in ^ unlocked_q;

	// ****************************************
	// Error tally
	// ****************************************
	// saturating count
	always_comb begin
		tally_d = tally_q;
		if (update_pulse) begin
			tally_d = count_now ? TALLY_W'(1) : BRX_TALLY_RST[TALLY_W-1:0];
		end else if (count_now && !tally_full) begin
			tally_d = tally_q + TALLY_W'(1);
		end
	end

	// Tally and tracking flops
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			tally_q       <= BRX_TALLY_RST[TALLY_W-1:0];
			unlocked_q    <= 1'b0;
			strobe_q      <= 1'b0;
			update_done_q <= 1'b0;
			nonzero_q     <= 1'b0;
		end else begin
			tally_q       <= tally_d;
			unlocked_q    <= pattern_unlocked_in;
			strobe_q      <= perf_update_strobe_in;
			update_done_q <= update_done_d;
			nonzero_q     <= nonzero_live;
		end
	end

	// visible copy loads on update only
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			visible_q <= BRX_TALLY_RST[TALLY_W-1:0];
		end else if (update_pulse) begin
			visible_q <= tally_q;
		end
	end

	// ****************************************
	// Latched flags, write one to clear
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < BRX_FLAG_N; gi++) begin : g_flag
			assign latched_d[gi] = events[gi] |
				(latched_q[gi] & ~(wr_latched & wr_data_in[gi]));
		end
	endgenerate

	// Flag and enable registers
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			latched_q <= BRX_FLAGS_RST;
			irq_en_q  <= BRX_FLAGS_RST;
		end else begin
			latched_q <= latched_d;
			if (wr_irq_en) begin
				irq_en_q <= brx_flags_t'(wr_data_in[BRX_FLAG_N-1:0]);
			end
		end
	end

	// ****************************************
	// Interrupt gating
	// ****************************************
	// no port gate on update done
	assign gated.update_done   = latched_q.update_done & irq_en_q.update_done;
	assign gated.bit_error     = latched_q.bit_error & irq_en_q.bit_error &
		port_irq_enable_field_in;
	assign gated.count_nonzero = latched_q.count_nonzero & irq_en_q.count_nonzero &
		port_irq_enable_field_in;
	assign gated.lock_change   = latched_q.lock_change & irq_en_q.lock_change &
		port_irq_enable_field_in;

	// request is OR of gated terms
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |gated;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// lock status in bit 0
	wire logic [BRX_DATA_W-1:0] live_word = {
		{(BRX_DATA_W-BRX_FLAG_N){1'b0}},
		update_done_q, 1'b0, nonzero_live,
		unlocked_q
	};

	always_comb begin
		if (sel_live) begin
			rd_mux = live_word;
		end else if (sel_latched) begin
			rd_mux = BRX_DATA_W'(latched_q);
		end else if (sel_irq_en) begin
			rd_mux = BRX_DATA_W'(irq_en_q);
		end else if (sel_count_lo) begin
			rd_mux = visible_q[BRX_LOW_W-1:0];
		end else if (sel_count_hi) begin
			rd_mux = BRX_DATA_W'(visible_q[TALLY_W-1:BRX_LOW_W]);
		end else begin
			rd_mux = BRX_DATA_ZERO;             // Unmapped reads zero
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			rd_data_q <= BRX_DATA_ZERO;
		end else begin
			rd_data_q <= rd_strobe_in ? rd_mux : BRX_DATA_ZERO;
		end
	end

	assign rd_data_out = rd_data_q;
	assign irq_out     = irq_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	property p_lock_read;
		rd_strobe_in && sel_live |=> rd_data_out[BRX_BIT_LOCK] == $past(unlocked_q);
	endproperty
	a_lock_read: assert property (p_lock_read)
		else $error("lock status bit wrong");

	property p_lock_track;
		##1 unlocked_q == $past(pattern_unlocked_in);
	endproperty
	a_lock_track: assert property (p_lock_track)
		else $error("lock status does not follow checker");

	property p_done_latch;
		$rose(update_done_q) |-> latched_q.update_done;
	endproperty
	a_done_latch: assert property (p_done_latch)
		else $error("update done rise not latched");

	property p_err_latch;
		bit_error_in |=> latched_q.bit_error;
	endproperty
	a_err_latch: assert property (p_err_latch)
		else $error("bit error not latched");

	property p_nz_latch;
		nonzero_live && !nonzero_q |=> latched_q.count_nonzero;
	endproperty
	a_nz_latch: assert property (p_nz_latch)
		else $error("nonzero rise not latched");

	property p_lock_latch;
		pattern_unlocked_in != unlocked_q |=> latched_q.lock_change;
	endproperty
	a_lock_latch: assert property (p_lock_latch)
		else $error("lock change not latched");

	property p_irq_done;
		latched_q.update_done && irq_en_q.update_done |=> irq_out;
	endproperty
	a_irq_done: assert property (p_irq_done)
		else $error("update done interrupt missing");

	property p_irq_err;
		latched_q.bit_error && irq_en_q.bit_error && port_irq_enable_field_in |=> irq_out;
	endproperty
	a_irq_err: assert property (p_irq_err)
		else $error("bit error interrupt missing");

	property p_irq_nz;
		latched_q.count_nonzero && irq_en_q.count_nonzero && port_irq_enable_field_in
			|=> irq_out;
	endproperty
	a_irq_nz: assert property (p_irq_nz)
		else $error("nonzero interrupt missing");

	property p_irq_lock;
		latched_q.lock_change && irq_en_q.lock_change && port_irq_enable_field_in
			|=> irq_out;
	endproperty
	a_irq_lock: assert property (p_irq_lock)
		else $error("lock change interrupt missing");

	property p_count_lo;
		rd_strobe_in && sel_count_lo |=> rd_data_out == $past(visible_q[BRX_LOW_W-1:0]);
	endproperty
	a_count_lo: assert property (p_count_lo)
		else $error("low count word wrong");

	property p_count_hi;
		rd_strobe_in && sel_count_hi |=>
			rd_data_out[BRX_DATA_W-1:BRX_HIGH_W] == '0 &&
			rd_data_out[BRX_HIGH_W-1:0] == $past(visible_q[TALLY_W-1:BRX_LOW_W]);
	endproperty
	a_count_hi: assert property (p_count_hi)
		else $error("high count word wrong");

	property p_saturate;
		tally_full && !update_pulse |=> tally_full;
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("tally wrapped");

	property p_count_step;
		count_now && !tally_full && !update_pulse |=> tally_q == $past(tally_q) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("tally missed an error");

	property p_oos_hold;
		pattern_unlocked_in && !update_pulse |=> $stable(tally_q);
	endproperty
	a_oos_hold: assert property (p_oos_hold)
		else $error("tally moved out of lock");

	property p_visible_hold;
		!update_pulse |=> $stable(visible_q);
	endproperty
	a_visible_hold: assert property (p_visible_hold)
		else $error("visible count changed without update");

	property p_visible_load;
		update_pulse |=> visible_q == $past(tally_q);
	endproperty
	a_visible_load: assert property (p_visible_load)
		else $error("visible count not loaded");

	property p_done_seq;
		update_pulse ##1 perf_update_strobe_in |-> update_done_q;
	endproperty
	a_done_seq: assert property (p_done_seq)
		else $error("update done did not rise");

	property p_done_drop;
		!perf_update_strobe_in |=> !update_done_q;
	endproperty
	a_done_drop: assert property (p_done_drop)
		else $error("update done not forced low");

	property p_nz_clear;
		update_pulse && !count_now |=> !nonzero_live;
	endproperty
	a_nz_clear: assert property (p_nz_clear)
		else $error("nonzero not cleared by update");

	property p_w0_keep;
		wr_latched && !wr_data_in[BRX_BIT_ERROR] && latched_q.bit_error
			|=> latched_q.bit_error;
	endproperty
	a_w0_keep: assert property (p_w0_keep)
		else $error("write of zero cleared a flag");

	property p_w1_clear;
		wr_latched && wr_data_in[BRX_BIT_LOCK] && !events.lock_change
			|=> !latched_q.lock_change;
	endproperty
	a_w1_clear: assert property (p_w1_clear)
		else $error("write of one did not clear");

	property p_irq_idle;
		gated == BRX_FLAGS_RST |=> !irq_out;
	endproperty
	a_irq_idle: assert property (p_irq_idle)
		else $error("interrupt without cause");

	c_saturate: cover property (tally_full && count_now);
	c_update: cover property (update_pulse ##1 update_done_q);
	c_lock_loss: cover property ($rose(pattern_unlocked_in) ##[1:20] irq_out);
	c_clear: cover property (wr_latched ##1 !irq_out);

endmodule

`default_nettype wire

// File: rtl/bec_pkg.sv
`default_nettype none

package brx_pkg;

	// ****************************************
	// Register map, byte offsets
	// ****************************************
	localparam int          BRX_ADDR_W        = 8;
	localparam int          BRX_DATA_W        = 16;
	localparam int          BRX_TALLY_W       = 24;
	localparam int          BRX_LOW_W         = 16;
	localparam int          BRX_HIGH_W        = BRX_TALLY_W - BRX_LOW_W;
	localparam int          BRX_FLAG_N        = 4;

	localparam logic [7:0]  BRX_OFS_LIVE      = 8'h6c;
	localparam logic [7:0]  BRX_OFS_LATCHED   = 8'h6e;
	localparam logic [7:0]  BRX_OFS_IRQ_EN    = 8'h70;
	localparam logic [7:0]  BRX_OFS_COUNT_LO  = 8'h74;
	localparam logic [7:0]  BRX_OFS_COUNT_HI  = 8'h76;

	// ****************************************
	// Field positions inside the 4-bit flag group
	// ****************************************
	localparam int          BRX_BIT_LOCK      = 0;
	localparam int          BRX_BIT_NONZERO   = 1;
	localparam int          BRX_BIT_ERROR     = 2;
	localparam int          BRX_BIT_DONE      = 3;

	// ****************************************
	// Reset values and tally maximum
	// ****************************************
	localparam logic [23:0] BRX_TALLY_MAX     = 24'hff_ffff;
	localparam logic [23:0] BRX_TALLY_RST     = 24'h00_0000;
	localparam logic [15:0] BRX_DATA_ZERO     = 16'h0000;

	// Four status sources, in register bit order (msb first)
	typedef struct packed {
		logic update_done;
		logic bit_error;
		logic count_nonzero;
		logic lock_change;
	} brx_flags_t;

	localparam brx_flags_t  BRX_FLAGS_RST     = '{default: 1'b0};

endpackage

`default_nettype wire

// File: testbench/bec_testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
	import brx_pkg::*;
;
	logic                  core_clk;
	logic                  reset_n;
	logic                  pattern_unlocked;
	logic                  bit_error;
	logic                  perf_update_strobe;
	logic                  port_irq_en;
	logic [BRX_ADDR_W-1:0] addr;
	logic [BRX_DATA_W-1:0] wr_data;
	logic                  wr_strobe;
	logic                  rd_strobe;
	logic [BRX_DATA_W-1:0] rd_data;
	logic                  irq;
	logic [BRX_DATA_W-1:0] got;
	int                    bad_count;
	int                    checks;

	// ****************************************
	// Device under test
	// ****************************************
	brx_error_counter DUT (
		.core_clk_in              (core_clk),
		.reset_n_in               (reset_n),
		.pattern_unlocked_in      (pattern_unlocked),
		.bit_error_in             (bit_error),
		.perf_update_strobe_in    (perf_update_strobe),
		.port_irq_enable_field_in (port_irq_en),
		.addr_in                  (addr),
		.wr_data_in               (wr_data),
		.wr_strobe_in             (wr_strobe),
		.rd_strobe_in             (rd_strobe),
		.rd_data_out              (rd_data),
		.irq_out                  (irq)
	);

	// Clock, 20 ns period
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr      <= a;
		wr_data   <= d;
		wr_strobe <= 1'b1;
		@(posedge core_clk);
		wr_strobe <= 1'b0;
	endtask

	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk);
		addr      <= a;
		rd_strobe <= 1'b1;
		@(posedge core_clk);
		rd_strobe <= 1'b0;
		// Data stand in this cycle; take them at its closing edge
		@(posedge core_clk);
		d = rd_data;
	endtask

	// Read and compare
	task automatic rdc(input logic [7:0] a, input logic [15:0] want);
		rd(a, got);
		chk(got, want);
	endtask

	// Wait a few cycles, then compare the interrupt output
	task automatic irqc(input logic want);
		repeat (3) @(posedge core_clk);
		chk({15'h0000, irq}, {15'h0000, want});
	endtask

	// Full update strobe cycle
	task automatic upd();
		@(posedge core_clk);
		perf_update_strobe <= 1'b1;
		repeat (3) @(posedge core_clk);
		perf_update_strobe <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	// Single error pulse
	task automatic err_pulse();
		@(posedge core_clk);
		bit_error <= 1'b1;
		@(posedge core_clk);
		bit_error <= 1'b0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Reset values, unmapped and read-only places
	task automatic t_reset();
		rdc(BRX_OFS_LIVE, 16'h0000);
		rdc(BRX_OFS_LATCHED, 16'h0000);
		rdc(BRX_OFS_IRQ_EN, 16'h0000);
		rdc(BRX_OFS_COUNT_LO, 16'h0000);
		rdc(BRX_OFS_COUNT_HI, 16'h0000);
		rdc(8'h80, 16'h0000);
		wr(BRX_OFS_COUNT_LO, 16'hffff);
		rdc(BRX_OFS_COUNT_LO, 16'h0000);
		irqc(1'b0);
	endtask

	// Enable register is read-write in its four bits
	task automatic t_enable();
		wr(BRX_OFS_IRQ_EN, 16'hffff);
		rdc(BRX_OFS_IRQ_EN, 16'h000f);
		wr(BRX_OFS_IRQ_EN, 16'h0000);
		rdc(BRX_OFS_IRQ_EN, 16'h0000);
	endtask

	// Error flags latch and clear only by writing ones
	task automatic t_error();
		err_pulse();
		rdc(BRX_OFS_LATCHED, 16'h0006);
		rdc(BRX_OFS_LIVE, 16'h0002);
		wr(BRX_OFS_LATCHED, 16'h0000);
		rdc(BRX_OFS_LATCHED, 16'h0006);
		wr(BRX_OFS_LATCHED, 16'h0004);
		rdc(BRX_OFS_LATCHED, 16'h0002);
		wr(BRX_OFS_LATCHED, 16'h0002);
		rdc(BRX_OFS_LATCHED, 16'h0000);
		rdc(BRX_OFS_COUNT_LO, 16'h0000);
	endtask

	// Interrupt gating, then an update
	task automatic t_irq();
		// Restart the tally so that the next error raises count nonzero again
		upd();
		rdc(BRX_OFS_COUNT_LO, 16'h0001);
		wr(BRX_OFS_LATCHED, 16'h0008);
		err_pulse();
		err_pulse();
		wr(BRX_OFS_IRQ_EN, 16'h0004);
		irqc(1'b0);
		port_irq_en <= 1'b1;
		irqc(1'b1);
		wr(BRX_OFS_IRQ_EN, 16'h0000);
		irqc(1'b0);
		wr(BRX_OFS_IRQ_EN, 16'h0002);
		irqc(1'b1);
		wr(BRX_OFS_LATCHED, 16'h0006);
		irqc(1'b0);
		port_irq_en <= 1'b0;
		wr(BRX_OFS_IRQ_EN, 16'h0008);
		@(posedge core_clk);
		perf_update_strobe <= 1'b1;
		rdc(BRX_OFS_LIVE, 16'h0008);
		rdc(BRX_OFS_LATCHED, 16'h0008);
		irqc(1'b1);
		rdc(BRX_OFS_COUNT_LO, 16'h0002);
		rdc(BRX_OFS_COUNT_HI, 16'h0000);
		perf_update_strobe <= 1'b0;
		repeat (2) @(posedge core_clk);
		rdc(BRX_OFS_LIVE, 16'h0000);
		wr(BRX_OFS_LATCHED, 16'h0008);
		irqc(1'b0);
		wr(BRX_OFS_IRQ_EN, 16'h0000);
	endtask

	// Lock loss: both edges latch, counting paused
	task automatic t_lock();
		pattern_unlocked <= 1'b1;
		repeat (3) @(posedge core_clk);
		rdc(BRX_OFS_LIVE, 16'h0001);
		rdc(BRX_OFS_LATCHED, 16'h0001);
		@(posedge core_clk);
		bit_error <= 1'b1;
		repeat (5) @(posedge core_clk);
		bit_error <= 1'b0;
		rdc(BRX_OFS_LATCHED, 16'h0005);
		wr(BRX_OFS_LATCHED, 16'h0005);
		pattern_unlocked <= 1'b0;
		repeat (3) @(posedge core_clk);
		rdc(BRX_OFS_LATCHED, 16'h0001);
		port_irq_en <= 1'b1;
		wr(BRX_OFS_IRQ_EN, 16'h0001);
		irqc(1'b1);
		wr(BRX_OFS_LATCHED, 16'h0001);
		irqc(1'b0);
		wr(BRX_OFS_IRQ_EN, 16'h0000);
		upd();
		rdc(BRX_OFS_COUNT_LO, 16'h0000);
		wr(BRX_OFS_LATCHED, 16'h000f);
	endtask

	// Count across the 16-bit boundary, hold until update
	task automatic t_big();
		@(posedge core_clk);
		bit_error <= 1'b1;
		repeat (65537) @(posedge core_clk);
		bit_error <= 1'b0;
		rdc(BRX_OFS_COUNT_LO, 16'h0000);
		upd();
		rdc(BRX_OFS_COUNT_LO, 16'h0001);
		rdc(BRX_OFS_COUNT_HI, 16'h0001);
		upd();
		rdc(BRX_OFS_COUNT_LO, 16'h0000);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		bad_count          = 0;
		checks             = 0;
		reset_n            = 1'b0;
		pattern_unlocked   = 1'b0;
		bit_error          = 1'b0;
		perf_update_strobe = 1'b0;
		port_irq_en        = 1'b0;
		addr               = 8'h00;
		wr_data            = 16'h0000;
		wr_strobe          = 1'b0;
		rd_strobe          = 1'b0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_enable();
		t_error();
		t_irq();
		t_lock();
		t_big();
		finish_test();
	end

	// Hang guard
	initial begin
		#1900000;
		bad_count++;
		finish_test();
	end
endmodule

`default_nettype wire
